// ===== verilog/mpc_check.sv
// Physical memory protection checker: entry store, priority match, verdicts
`timescale 1ns/1ps
module mpc_check (
    input  wire logic                              REF_CLK,
    input  wire logic                              RST,
    // Machine-level configuration writes
    input  wire logic                              CFG_WE,
    input  wire logic [mpc_pkg::IDX_W-1:0]         CFG_IDX,
    input  wire logic [mpc_pkg::CFG_W-1:0]         CFG_DATA,
    input  wire logic                              BOUND_WE,
    input  wire logic [mpc_pkg::IDX_W-1:0]         BOUND_IDX,
    input  wire logic [mpc_pkg::BOUND_W-1:0]       BOUND_DATA,
    // Readback of one entry
    input  wire logic [mpc_pkg::IDX_W-1:0]         RD_IDX,
    output logic      [mpc_pkg::CFG_W-1:0]         RD_CFG,
    output logic      [mpc_pkg::BOUND_W-1:0]       RD_BOUND,
    // Access request from fetch, load/store or page walk
    input  wire logic                              REQ_VALID,
    input  wire logic [mpc_pkg::PA_W-1:0]          REQ_ADDR,
    input  wire logic [mpc_pkg::SIZE_W-1:0]        REQ_SIZE,
    input  wire logic [1:0]                        REQ_TYPE,
    input  wire logic [1:0]                        REQ_PRIV,
    input  wire logic                              REQ_PTW,
    input  wire logic                              REQ_LAST,
    // Same-cycle verdict
    output logic                                   RSP_FAIL,
    output logic      [1:0]                        RSP_EXC,
    // Per-instruction summary
    output logic                                   INSN_DONE,
    output logic                                   INSN_FAULT,
    output logic      [1:0]                        INSN_EXC
);
    localparam int N = mpc_pkg::NUM_ENTRIES;

    logic [mpc_pkg::CFG_W-1:0]   cfg   [N];
    logic [mpc_pkg::BOUND_W-1:0] bound [N];
    logic [N-1:0]                any_hit;
    logic [N-1:0]                all_hit;
    logic [N-1:0]                lock_next_tor;

    logic [1:0]                  eff_priv;
    logic [mpc_pkg::CMP_W-1:0]   req_lo;
    logic [mpc_pkg::CMP_W-1:0]   req_hi;
    logic                        hit_found;
    logic [mpc_pkg::IDX_W-1:0]   sel;
    logic [mpc_pkg::CFG_W-1:0]   sel_cfg;
    logic                        fail;

    mpc_pkg::mpc_state_t         state;
    mpc_pkg::mpc_state_t         next_state;
    logic                        acc_fault;
    logic                        next_acc_fault;
    logic [1:0]                  acc_exc;
    logic [1:0]                  next_acc_exc;
    logic                        next_insn_done;
    logic                        next_insn_fault;
    logic [1:0]                  next_insn_exc;
    logic                        merged_fault;
    logic [1:0]                  merged_exc;
    logic [mpc_pkg::CFG_W-1:0]   next_rd_cfg;
    logic [mpc_pkg::BOUND_W-1:0] next_rd_bound;

    function automatic logic [1:0] region_mode(input logic [mpc_pkg::CFG_W-1:0] c);
        region_mode = c[mpc_pkg::CFG_A_HI:mpc_pkg::CFG_A_LO];
    endfunction : region_mode

    // Byte span minus one for an access of 1, 2, 4 or 8 bytes
    function automatic logic [mpc_pkg::CMP_W-1:0] size_span(input logic [mpc_pkg::SIZE_W-1:0] s);
        case (s)
            2'h0:    size_span = 35'h0_0000_0000;
            2'h1:    size_span = 35'h0_0000_0001;
            2'h2:    size_span = 35'h0_0000_0003;
            default: size_span = 35'h0_0000_0007;
        endcase
    endfunction : size_span

    function automatic logic type_permitted(input logic [mpc_pkg::CFG_W-1:0] c, input logic [1:0] t);
        case (t)
            mpc_pkg::ACC_FETCH: type_permitted = c[mpc_pkg::CFG_X];
            mpc_pkg::ACC_LOAD:  type_permitted = c[mpc_pkg::CFG_R];
            default:            type_permitted = c[mpc_pkg::CFG_W_B];
        endcase
    endfunction : type_permitted

    function automatic logic [1:0] exc_of(input logic [1:0] t);
        case (t)
            mpc_pkg::ACC_FETCH: exc_of = mpc_pkg::EXC_FETCH;
            mpc_pkg::ACC_LOAD:  exc_of = mpc_pkg::EXC_LOAD;
            default:            exc_of = mpc_pkg::EXC_STORE;
        endcase
    endfunction : exc_of

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_entry
            if (gi < N - 1) begin : g_guard
                assign lock_next_tor[gi] = cfg[gi+1][mpc_pkg::CFG_L] &&
                    (region_mode(cfg[gi+1]) == mpc_pkg::MODE_UPPER_BOUND_RANGE);
            end else begin : g_top
                assign lock_next_tor[gi] = 1'b0;
            end

            mpc_entry_regs u_regs (
                .clk           (REF_CLK),
                .rst           (RST),
                .cfg_we        (CFG_WE && (CFG_IDX == gi[mpc_pkg::IDX_W-1:0])),
                .bound_we      (BOUND_WE && (BOUND_IDX == gi[mpc_pkg::IDX_W-1:0])),
                .wr_cfg        (CFG_DATA),
                .wr_bound      (BOUND_DATA),
                .lock_next_tor (lock_next_tor[gi]),
                .cfg           (cfg[gi]),
                .bound         (bound[gi])
            );

            mpc_entry_match u_match (
                .cfg        (cfg[gi]),
                .bound      (bound[gi]),
                .prev_bound ((gi == 0) ? mpc_pkg::BOUND_RST : bound[(gi == 0) ? 0 : gi-1]),
                .req_lo     (req_lo),
                .req_hi     (req_hi),
                .any_hit    (any_hit[gi]),
                .all_hit    (all_hit[gi])
            );
        end
    endgenerate

    // Verdict path is purely combinational on live settings, so a
    // reconfiguration is seen by the very next access without a fence
    always_comb begin
        // Page-walk references always carry supervisor privilege
        eff_priv = REQ_PTW ? mpc_pkg::PRIV_SUPER : REQ_PRIV;
        req_lo   = {1'b0, REQ_ADDR};
        req_hi   = req_lo + size_span(REQ_SIZE);
        hit_found = 1'b0;
        sel       = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (any_hit[i]) begin
                hit_found = 1'b1;
                sel       = 4'(i);
            end
        end
        sel_cfg = cfg[sel];
        if (!hit_found) begin
            fail = (eff_priv != mpc_pkg::PRIV_MACH);
        end else if (!all_hit[sel]) begin
            fail = 1'b1;
        end else if (!sel_cfg[mpc_pkg::CFG_L] && (eff_priv == mpc_pkg::PRIV_MACH)) begin
            fail = 1'b0;
        end else begin
            fail = !type_permitted(sel_cfg, REQ_TYPE);
        end
        RSP_FAIL = REQ_VALID && fail;
        RSP_EXC  = RSP_FAIL ? exc_of(REQ_TYPE) : mpc_pkg::EXC_NONE;
    end

    // Pieces of a split or multi-access instruction are judged one by one;
    // a piece already passed is not recalled, only the summary faults
    always_comb begin
        next_state      = state;
        next_acc_fault  = acc_fault;
        next_acc_exc    = acc_exc;
        next_insn_done  = 1'b0;
        next_insn_fault = INSN_FAULT;
        next_insn_exc   = INSN_EXC;
        merged_fault    = acc_fault || RSP_FAIL;
        merged_exc      = acc_fault ? acc_exc : RSP_EXC;
        case (state)
            mpc_pkg::MPC_ST_IDLE,
            mpc_pkg::MPC_ST_ACCUM: begin
                if (REQ_VALID) begin
                    if (REQ_LAST) begin
                        next_insn_done  = 1'b1;
                        next_insn_fault = merged_fault;
                        next_insn_exc   = merged_exc;
                        next_acc_fault  = 1'b0;
                        next_acc_exc    = mpc_pkg::EXC_NONE;
                        next_state      = mpc_pkg::MPC_ST_IDLE;
                    end else begin
                        next_acc_fault  = merged_fault;
                        next_acc_exc    = merged_exc;
                        next_state      = mpc_pkg::MPC_ST_ACCUM;
                    end
                end
            end
            default: begin
                next_state     = mpc_pkg::MPC_ST_IDLE;
                next_acc_fault = 1'b0;
                next_acc_exc   = mpc_pkg::EXC_NONE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state      <= mpc_pkg::MPC_ST_IDLE;
            acc_fault  <= 1'b0;
            acc_exc    <= mpc_pkg::EXC_NONE;
            INSN_DONE  <= 1'b0;
            INSN_FAULT <= 1'b0;
            INSN_EXC   <= mpc_pkg::EXC_NONE;
        end else begin
            state      <= next_state;
            acc_fault  <= next_acc_fault;
            acc_exc    <= next_acc_exc;
            INSN_DONE  <= next_insn_done;
            INSN_FAULT <= next_insn_fault;
            INSN_EXC   <= next_insn_exc;
        end
    end

    // Readback is registered: one cycle from index to data
    always_comb begin
        next_rd_cfg   = cfg[RD_IDX];
        next_rd_bound = bound[RD_IDX];
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RD_CFG   <= mpc_pkg::CFG_RST;
            RD_BOUND <= mpc_pkg::BOUND_RST;
        end else begin
            RD_CFG   <= next_rd_cfg;
            RD_BOUND <= next_rd_bound;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_fault_piece;
        REQ_VALID && RSP_FAIL && !REQ_LAST;
    endsequence

    sequence s_last_piece;
        REQ_VALID && REQ_LAST;
    endsequence

    a_nomatch_mach_pass: assert property (
        REQ_VALID && (any_hit == '0) && (eff_priv == mpc_pkg::PRIV_MACH) |-> !RSP_FAIL)
        else $error("unmatched machine access failed");
    a_nomatch_low_fail: assert property (
        REQ_VALID && (any_hit == '0) && (eff_priv != mpc_pkg::PRIV_MACH) |-> RSP_FAIL)
        else $error("unmatched lower-privilege access passed");
    a_partial_cover_fail: assert property (
        REQ_VALID && hit_found && !all_hit[sel] |-> RSP_FAIL)
        else $error("partially covered access passed");
    a_lowest_entry_wins: assert property (
        hit_found |-> ((any_hit & ((16'h0001 << sel) - 16'h0001)) == 16'h0000) && any_hit[sel])
        else $error("deciding entry is not lowest match");
    a_open_mach_pass: assert property (
        REQ_VALID && hit_found && all_hit[sel] && !sel_cfg[mpc_pkg::CFG_L] &&
        (REQ_PRIV == mpc_pkg::PRIV_MACH) && !REQ_PTW |-> !RSP_FAIL)
        else $error("machine access under open entry failed");
    a_ptw_as_super: assert property (
        REQ_VALID && REQ_PTW && (any_hit == '0) |-> RSP_FAIL)
        else $error("page-walk reference not checked as supervisor");
    a_exc_matches_type: assert property (
        RSP_FAIL |-> (RSP_EXC != mpc_pkg::EXC_NONE) &&
        ((REQ_TYPE == mpc_pkg::ACC_FETCH) == (RSP_EXC == mpc_pkg::EXC_FETCH)) &&
        ((REQ_TYPE == mpc_pkg::ACC_LOAD) == (RSP_EXC == mpc_pkg::EXC_LOAD)))
        else $error("exception kind does not match access type");
    a_pass_no_exc: assert property (
        !RSP_FAIL |-> RSP_EXC == mpc_pkg::EXC_NONE)
        else $error("exception reported for passing access");
    a_frozen_mach_denied: assert property (
        REQ_VALID && hit_found && all_hit[sel] && sel_cfg[mpc_pkg::CFG_L] &&
        !type_permitted(sel_cfg, REQ_TYPE) |-> RSP_FAIL)
        else $error("frozen entry permission not enforced");
    a_denied_perm_fails: assert property (
        REQ_VALID && hit_found && all_hit[sel] && (eff_priv != mpc_pkg::PRIV_MACH) &&
        !type_permitted(sel_cfg, REQ_TYPE) |-> RSP_FAIL)
        else $error("access without permission passed");
    a_group_fault_kept: assert property (
        s_fault_piece ##1 s_last_piece |=> INSN_DONE && INSN_FAULT)
        else $error("earlier failing piece lost from instruction");
    a_single_done: assert property (
        ((state == mpc_pkg::MPC_ST_IDLE) and s_last_piece) |=>
        INSN_DONE && (INSN_FAULT == $past(RSP_FAIL)) && (INSN_EXC == $past(RSP_EXC)))
        else $error("single access summary wrong");
endmodule : mpc_check

// ===== verilog/mpc_pkg.sv
// Shared constants and types for the physical memory protection checker
package mpc_pkg;
    // Entry count and widths
    localparam int NUM_ENTRIES = 16;
    localparam int IDX_W       = 4;
    localparam int BOUND_W     = 32;
    localparam int PA_W        = 34;
    localparam int CMP_W       = 35;
    localparam int CFG_W       = 8;
    localparam int SIZE_W      = 2;

    // Field positions inside an entry_config_byte
    localparam int CFG_R    = 0;
    localparam int CFG_W_B  = 1;
    localparam int CFG_X    = 2;
    localparam int CFG_A_LO = 3;
    localparam int CFG_A_HI = 4;
    localparam int CFG_RSV_LO = 5;
    localparam int CFG_RSV_HI = 6;
    localparam int CFG_L    = 7;

    // Values after reset
    localparam logic [CFG_W-1:0]   CFG_RST   = 8'h00;
    localparam logic [BOUND_W-1:0] BOUND_RST = 32'h0000_0000;

    // Region style encodings
    localparam logic [1:0] MODE_OFF                 = 2'h0;
    localparam logic [1:0] MODE_UPPER_BOUND_RANGE   = 2'h1;
    localparam logic [1:0] MODE_FOUR_BYTE_REGION    = 2'h2;
    localparam logic [1:0] MODE_POW2_ALIGNED_REGION = 2'h3;

    // Privilege of an access
    localparam logic [1:0] PRIV_USER  = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] PRIV_MACH  = 2'h3;

    // Access types
    localparam logic [1:0] ACC_FETCH = 2'h0;
    localparam logic [1:0] ACC_LOAD  = 2'h1;
    localparam logic [1:0] ACC_STORE = 2'h2;

    // Exception kinds reported back
    localparam logic [1:0] EXC_NONE  = 2'h0;
    localparam logic [1:0] EXC_FETCH = 2'h1;
    localparam logic [1:0] EXC_LOAD  = 2'h2;
    localparam logic [1:0] EXC_STORE = 2'h3;

    typedef enum logic [1:0] {
        MPC_ST_IDLE  = 2'b01,
        MPC_ST_ACCUM = 2'b10
    } mpc_state_t;
endpackage : mpc_pkg

// ===== verilog/mpc_entry_regs.sv
// One protection entry: config byte and bound register with freeze logic
`timescale 1ns/1ps
module mpc_entry_regs (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            cfg_we,
    input  wire logic                            bound_we,
    input  wire logic [mpc_pkg::CFG_W-1:0]       wr_cfg,
    input  wire logic [mpc_pkg::BOUND_W-1:0]     wr_bound,
    input  wire logic                            lock_next_tor,
    output logic      [mpc_pkg::CFG_W-1:0]       cfg,
    output logic      [mpc_pkg::BOUND_W-1:0]     bound
);
    logic [mpc_pkg::CFG_W-1:0]   next_cfg;
    logic [mpc_pkg::BOUND_W-1:0] next_bound;

    always_comb begin
        next_cfg   = cfg;
        next_bound = bound;
        // A frozen entry ignores both writes; freeze cannot be cleared by writing
        if (cfg_we && !cfg[mpc_pkg::CFG_L]) begin
            next_cfg = wr_cfg;
            next_cfg[mpc_pkg::CFG_RSV_HI:mpc_pkg::CFG_RSV_LO] = 2'h0;
            // Write-only without read is reserved, kept legal by dropping write
            if (!wr_cfg[mpc_pkg::CFG_R]) begin
                next_cfg[mpc_pkg::CFG_W_B] = 1'b0;
            end
        end
        if (bound_we && !cfg[mpc_pkg::CFG_L] && !lock_next_tor) begin
            next_bound = wr_bound;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg   <= mpc_pkg::CFG_RST;
            bound <= mpc_pkg::BOUND_RST;
        end else begin
            cfg   <= next_cfg;
            bound <= next_bound;
        end
    end

    a_frozen_cfg_kept: assert property (@(posedge clk) disable iff (rst)
        cfg[mpc_pkg::CFG_L] |=> cfg[mpc_pkg::CFG_L] && $stable(cfg) && $stable(bound))
        else $error("frozen entry changed");
    a_below_bound_kept: assert property (@(posedge clk) disable iff (rst)
        lock_next_tor && bound_we |=> $stable(bound))
        else $error("bound under frozen range entry changed");
    a_open_write_lands: assert property (@(posedge clk) disable iff (rst)
        cfg_we && !cfg[mpc_pkg::CFG_L] |=> cfg[mpc_pkg::CFG_L] == $past(wr_cfg[mpc_pkg::CFG_L]))
        else $error("open config write lost");
endmodule : mpc_entry_regs

// ===== verilog/mpc_entry_match.sv
// Address match of one entry against a byte range
`timescale 1ns/1ps
module mpc_entry_match (
    input  wire logic [mpc_pkg::CFG_W-1:0]   cfg,
    input  wire logic [mpc_pkg::BOUND_W-1:0] bound,
    input  wire logic [mpc_pkg::BOUND_W-1:0] prev_bound,
    input  wire logic [mpc_pkg::CMP_W-1:0]   req_lo,
    input  wire logic [mpc_pkg::CMP_W-1:0]   req_hi,
    output logic                             any_hit,
    output logic                             all_hit
);
    logic [mpc_pkg::BOUND_W-1:0] mask;
    logic [mpc_pkg::CMP_W-1:0]   rlo;
    logic [mpc_pkg::CMP_W-1:0]   rhi;
    logic [mpc_pkg::CMP_W-1:0]   top;
    logic                        region_ok;

    always_comb begin
        // Trailing ones plus the first zero drop out of the compare
        mask      = ~(bound ^ (bound + 32'h0000_0001));
        top       = {1'b0, bound, 2'b00};
        rlo       = '0;
        rhi       = '0;
        region_ok = 1'b0;
        case (cfg[mpc_pkg::CFG_A_HI:mpc_pkg::CFG_A_LO])
            mpc_pkg::MODE_UPPER_BOUND_RANGE: begin
                rlo       = {1'b0, prev_bound, 2'b00};
                region_ok = top > rlo;
                rhi       = top - 35'h0_0000_0001;
            end
            mpc_pkg::MODE_FOUR_BYTE_REGION: begin
                rlo       = top;
                rhi       = top | 35'h0_0000_0003;
                region_ok = 1'b1;
            end
            mpc_pkg::MODE_POW2_ALIGNED_REGION: begin
                rlo       = {1'b0, bound & mask, 2'b00};
                rhi       = {1'b0, bound | ~mask, 2'b11};
                region_ok = 1'b1;
            end
            default: begin
                region_ok = 1'b0;
            end
        endcase
        any_hit = region_ok && (req_lo <= rhi) && (req_hi >= rlo);
        all_hit = region_ok && (req_lo >= rlo) && (req_hi <= rhi);
    end
endmodule : mpc_entry_match

// ===== verification/mpc_req_model.sv
// Requester model: fetch, load/store and page-walk access pieces
`timescale 1ns/1ps
module mpc_req_model (
    output logic                       req_valid,
    output logic [mpc_pkg::PA_W-1:0]   req_addr,
    output logic [mpc_pkg::SIZE_W-1:0] req_size,
    output logic [1:0]                 req_type,
    output logic [1:0]                 req_priv,
    output logic                       req_ptw,
    output logic                       req_last
);
    initial begin
        {req_valid, req_addr, req_size, req_type, req_priv, req_ptw, req_last} = '0;
    end

    // One piece per call; the caller holds it for a whole cycle
    task send(input logic [33:0] a, input logic [1:0] s, t, p, input logic w, l);
        req_valid = 1'b1;
        req_addr  = a;
        req_size  = s;
        req_type  = t;
        req_priv  = p;
        req_ptw   = w;
        req_last  = l;
    endtask : send

    // Released lines must not keep the old piece looking valid
    task idle;
        req_valid = 1'b0;
        req_addr  = ~req_addr;
        req_size  = ~req_size;
        req_last  = ~req_last;
    endtask : idle
endmodule : mpc_req_model

// ===== verification/mpc_check_bench.sv
// Self-checking bench for the protection checker
`timescale 1ns/1ps
module mpc_check_bench;
    localparam logic [1:0] FE = mpc_pkg::ACC_FETCH, LD = mpc_pkg::ACC_LOAD, ST = mpc_pkg::ACC_STORE;
    localparam logic [1:0] U = mpc_pkg::PRIV_USER, S = mpc_pkg::PRIV_SUPER, M = mpc_pkg::PRIV_MACH;
    localparam logic [1:0] XN = mpc_pkg::EXC_NONE, XF = mpc_pkg::EXC_FETCH;
    localparam logic [1:0] XL = mpc_pkg::EXC_LOAD, XS = mpc_pkg::EXC_STORE;
    typedef struct packed {
        logic [33:0] addr;
        logic [1:0]  size;
        logic [1:0]  typ;
        logic [1:0]  priv;
        logic        ptw;
        logic        fail;
        logic [1:0]  exc;
    } mpc_row_t;
    // Entries: 0 range [0,100) R, 1 four-byte 200 RWX, 2 pow2 300/8 R, 3 frozen range [300,400) R, 4 pow2 400/16 RW
    logic [7:0]  ent_cfg [5] = '{8'h09, 8'h17, 8'h19, 8'h89, 8'h1B};
    logic [31:0] ent_bnd [5] = '{32'h40, 32'h80, 32'hC0, 32'h100, 32'h101};
    mpc_row_t rows [18] = '{
        '{34'h000, 2'h2, LD, M, 1'b0, 1'b0, XN},
        '{34'h010, 2'h2, ST, U, 1'b0, 1'b1, XS},
        '{34'h0FC, 2'h3, FE, U, 1'b0, 1'b1, XF},
        '{34'h010, 2'h2, ST, M, 1'b0, 1'b0, XN},
        '{34'h200, 2'h2, LD, U, 1'b0, 1'b0, XN},
        '{34'h202, 2'h1, FE, S, 1'b0, 1'b0, XN},
        '{34'h1FE, 2'h2, LD, U, 1'b0, 1'b1, XL},
        '{34'h300, 2'h3, ST, M, 1'b0, 1'b0, XN},
        '{34'h304, 2'h3, LD, U, 1'b0, 1'b1, XL},
        '{34'h310, 2'h2, ST, M, 1'b0, 1'b1, XS},
        '{34'h310, 2'h2, LD, M, 1'b0, 1'b0, XN},
        '{34'h800, 2'h2, LD, M, 1'b0, 1'b0, XN},
        '{34'h800, 2'h2, LD, U, 1'b0, 1'b1, XL},
        '{34'h800, 2'h0, FE, S, 1'b0, 1'b1, XF},
        '{34'h800, 2'h2, LD, M, 1'b1, 1'b1, XL},
        '{34'h40C, 2'h2, ST, U, 1'b0, 1'b0, XN},
        '{34'h410, 2'h2, ST, U, 1'b0, 1'b1, XS},
        '{34'h800, 2'h2, 2'h3, U, 1'b0, 1'b1, XS}
    };
    logic        REF_CLK = 1'b0, RST = 1'b1, CFG_WE = 1'b0, BOUND_WE = 1'b0;
    logic [3:0]  CFG_IDX = '0, BOUND_IDX = '0, RD_IDX = '0;
    logic [7:0]  CFG_DATA = '0;
    logic [31:0] BOUND_DATA = '0;
    logic [7:0]  RD_CFG;
    logic [31:0] RD_BOUND;
    logic        REQ_VALID, REQ_PTW, REQ_LAST, RSP_FAIL, INSN_DONE, INSN_FAULT;
    logic [33:0] REQ_ADDR;
    logic [1:0]  REQ_SIZE, REQ_TYPE, REQ_PRIV, RSP_EXC, INSN_EXC;
    int          error_cnt = 0;
    int          comparisons = 0;

    mpc_check dut_u (.REF_CLK(REF_CLK), .RST(RST), .CFG_WE(CFG_WE), .CFG_IDX(CFG_IDX), .CFG_DATA(CFG_DATA),
        .BOUND_WE(BOUND_WE), .BOUND_IDX(BOUND_IDX), .BOUND_DATA(BOUND_DATA), .RD_IDX(RD_IDX), .RD_CFG(RD_CFG),
        .RD_BOUND(RD_BOUND), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .REQ_SIZE(REQ_SIZE),
        .REQ_TYPE(REQ_TYPE), .REQ_PRIV(REQ_PRIV), .REQ_PTW(REQ_PTW), .REQ_LAST(REQ_LAST),
        .RSP_FAIL(RSP_FAIL), .RSP_EXC(RSP_EXC), .INSN_DONE(INSN_DONE), .INSN_FAULT(INSN_FAULT),
        .INSN_EXC(INSN_EXC));
    mpc_req_model req_u (.req_valid(REQ_VALID), .req_addr(REQ_ADDR), .req_size(REQ_SIZE),
        .req_type(REQ_TYPE), .req_priv(REQ_PRIV), .req_ptw(REQ_PTW), .req_last(REQ_LAST));

    initial begin
        forever #5 REF_CLK = ~REF_CLK;
    end

    task chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task step;
        @(posedge REF_CLK);
        #1;
    endtask : step

    task wcfg(input logic [3:0] i, input logic [7:0] d);
        CFG_WE = 1'b1;
        CFG_IDX = i;
        CFG_DATA = d;
        step();
        CFG_WE = 1'b0;
    endtask : wcfg

    task wbnd(input logic [3:0] i, input logic [31:0] d);
        BOUND_WE = 1'b1;
        BOUND_IDX = i;
        BOUND_DATA = d;
        step();
        BOUND_WE = 1'b0;
    endtask : wbnd

    task rd(input logic [3:0] i, input logic [7:0] c, input logic [31:0] b);
        RD_IDX = i;
        step();
        step();
        chk(32'(RD_CFG), 32'(c));
        chk(RD_BOUND, b);
    endtask : rd

    // Single piece, verdict in the same cycle, summary one cycle on
    task piece(input mpc_row_t r);
        req_u.send(r.addr, r.size, r.typ, r.priv, r.ptw, 1'b1);
        #1;
        chk({RSP_FAIL, RSP_EXC}, {r.fail, r.exc});
        step();
        req_u.idle();
        #1;
        chk({INSN_DONE, INSN_FAULT, INSN_EXC}, {1'b1, r.fail, r.exc});
        step();
    endtask : piece

    initial begin
        repeat (20) @(posedge REF_CLK);
        #1;
        RST = 1'b0;
        for (int i = 0; i < 5; i++) begin
            wbnd(4'(i), ent_bnd[i]);
            wcfg(4'(i), ent_cfg[i]);
        end
        foreach (rows[k]) piece(rows[k]);
        $display("Table of access checks done");
        wcfg(4'h3, 8'h00);
        wbnd(4'h3, 32'h0);
        step();
        wbnd(4'h2, 32'h0);
        wcfg(4'h2, 8'h1B);
        rd(4'h3, 8'h89, 32'h100);
        rd(4'h2, 8'h1B, 32'hC0);
        $display("Frozen entry writes done");
        // Write lands at its edge; no request overlaps it, standing in for the fence
        wcfg(4'h0, 8'h0B);
        piece('{34'h010, 2'h2, ST, U, 1'b0, 1'b0, XN});
        req_u.send(34'h800, 2'h2, LD, U, 1'b0, 1'b0);
        #1;
        chk(32'(RSP_FAIL), 32'h1);
        step();
        req_u.send(34'h010, 2'h2, ST, U, 1'b0, 1'b1);
        #1;
        chk(32'(RSP_FAIL), 32'h0);
        step();
        req_u.idle();
        #1;
        chk({INSN_DONE, INSN_FAULT, INSN_EXC}, {1'b1, 1'b1, XL});
        step();
        chk({INSN_DONE, INSN_FAULT, INSN_EXC}, {1'b0, 1'b1, XL});
        $display("Split instruction done");
        RST = 1'b1;
        step();
        step();
        RST = 1'b0;
        rd(4'h3, 8'h00, 32'h0);
        wcfg(4'h3, 8'h01);
        rd(4'h3, 8'h01, 32'h0);
        piece('{34'h000, 2'h2, LD, U, 1'b0, 1'b1, XL});
        piece('{34'h000, 2'h2, LD, M, 1'b0, 1'b0, XN});
        $display("Reset test done");
        finish_test();
    end
endmodule : mpc_check_bench
